/* afe_cfg_regs.sv */
// Serial-accessed configuration and identification register bank.
`timescale 1ns/1ps
module afe_cfg_regs
	import afe_cfg_pkg::*;
#(
	parameter int TEST_SLOW_DIV_LOG2 = TEST_SLOW_LOG2,
	parameter int TEST_FAST_DIV_LOG2 = TEST_FAST_LOG2
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic       din,
	input  wire logic       clock_source_pin,
	output logic            dout,
	output logic            dout_oe_n,
	output logic            readback_multi,
	output logic            osc_clk_out_en,
	output logic [2:0]      output_rate_code,
	output logic            result_24bit,
	output logic            test_internal,
	output logic            test_amp_x2,
	output logic [1:0]      test_frequency_select,
	output logic            sample_tick,
	output logic            test_signal
);

	spi_state_t s;
	spi_state_t next_s;
	logic [7:0] cfg1;
	logic [7:0] cfg2;
	logic [7:0] cfg3;
	logic [7:0] next_cfg1;
	logic [7:0] next_cfg2;
	logic [7:0] next_cfg3;
	cfg_out_t   outs;
	cfg_out_t   next_outs;
	logic       sclk_rise;
	logic       sclk_fall;
	logic [7:0] rx_byte;
	logic [7:0] rd_byte;
	logic [7:0] id_value;
	logic [7:0] cfg2_view;
	logic [7:0] cfg3_view;
	logic       wr_strobe;
	logic [4:0] wr_addr;
	logic [7:0] wr_data;

	////////////////////////////////////////////////////////////////////////////////
	// Fixed and forced bits, built one bit at a time. The identification value is pure
	// wiring, so neither a write nor a reset can ever disturb it.
	for (genvar b = 0; b < 8; b++) begin : g_fixed_bits
		if (b == ID_FAMILY_BIT) begin : g_family
			assign id_value[b] = FAMILY_CODE;
		end else begin : g_pattern
			assign id_value[b] = ID_FIXED_PATTERN[b];
		end
		// Reserved bits read their required level whatever the host last wrote.
		assign cfg2_view[b] = (cfg2[b] | CFG2_READ_ONES[b]) & ~CFG2_READ_ZEROS[b];
		assign cfg3_view[b] = cfg3[b] & ~CFG3_READ_ZEROS[b];
	end

	// Read mux. Unmapped addresses read zero.
	always_comb begin
		case (s.addr)
			ADDR_ID:   rd_byte = id_value;
			ADDR_CFG1: rd_byte = cfg1;
			ADDR_CFG2: rd_byte = cfg2_view;
			ADDR_CFG3: rd_byte = cfg3_view;
			default:   rd_byte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial engine and register writes. Serial pins are sampled on the master clock,
	// so the serial clock must stay well below half of it.
	always_comb begin
		next_s    = s;
		wr_strobe = 1'b0;
		wr_addr   = s.addr;
		next_s.sclk_q = sclk;
		sclk_rise = sclk && !s.sclk_q;
		sclk_fall = !sclk && s.sclk_q;
		rx_byte   = {s.rx_shift[6:0], din};
		wr_data   = rx_byte;
		if (cs_n) begin
			// Deselect aborts any command and frees the data line.
			next_s.phase     = PH_CMD;
			next_s.rx_cnt    = 3'h0;
			next_s.tx_cnt    = 3'h0;
			next_s.dout      = 1'b0;
			next_s.dout_oe_n = 1'b1;
		end else begin
			next_s.dout_oe_n = 1'b0;
			// Rising edges shift read data out, most significant bit first.
			if (sclk_rise && s.phase == PH_DATA && !s.is_write) begin
				if (s.tx_cnt == 3'h0) begin
					next_s.dout     = rd_byte[7];
					next_s.tx_shift = {rd_byte[6:0], 1'b0};
				end else begin
					next_s.dout     = s.tx_shift[7];
					next_s.tx_shift = {s.tx_shift[6:0], 1'b0};
				end
				next_s.tx_cnt = s.tx_cnt + 3'h1;
			end
			// Falling edges sample input bits; decisions are made per whole byte.
			if (sclk_fall) begin
				next_s.rx_shift = rx_byte;
				next_s.rx_cnt   = s.rx_cnt + 3'h1;
				if (s.rx_cnt == 3'h7) begin
					case (s.phase)
						PH_CMD: begin
							if (rx_byte[7:5] == OP_READ || rx_byte[7:5] == OP_WRITE) begin
								next_s.is_write = (rx_byte[7:5] == OP_WRITE);
								next_s.addr     = rx_byte[4:0];
								next_s.phase    = PH_COUNT;
							end
						end
						PH_COUNT: begin
							next_s.remain = rx_byte[4:0];
							next_s.tx_cnt = 3'h0;
							next_s.phase  = PH_DATA;
						end
						PH_DATA: begin
							// Each completed data byte of a write is one register strobe.
							wr_strobe = s.is_write;
							next_s.addr = s.addr + 5'h01;
							if (s.remain == 5'h00) begin
								next_s.phase = PH_SKIP;
							end else begin
								next_s.remain = s.remain - 5'h01;
							end
						end
						PH_SKIP: next_s.phase = PH_SKIP;
						default: next_s.phase = PH_CMD;
					endcase
				end
			end
		end
	end

	// Engine state. The edge detector parks low like the idle serial clock, so no false
	// edge follows reset.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{
				phase:     PH_CMD,
				sclk_q:    1'b0,
				rx_cnt:    3'h0,
				rx_shift:  8'h00,
				tx_cnt:    3'h0,
				tx_shift:  8'h00,
				is_write:  1'b0,
				addr:      5'h00,
				remain:    5'h00,
				dout:      1'b0,
				dout_oe_n: 1'b1
			};
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register file. Identification and unmapped addresses ignore writes.
	always_comb begin
		next_cfg1 = cfg1;
		next_cfg2 = cfg2;
		next_cfg3 = cfg3;
		if (wr_strobe) begin
			case (wr_addr)
				ADDR_CFG1: next_cfg1 = wr_data;
				ADDR_CFG2: next_cfg2 = wr_data;
				ADDR_CFG3: next_cfg3 = wr_data;
				default:   next_cfg1 = cfg1;
			endcase
		end
	end

	// Reset restores the defaults; only host writes move them afterwards.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg1 <= CFG1_RESET;
			cfg2 <= CFG2_RESET;
			cfg3 <= CFG3_RESET;
		end else begin
			cfg1 <= next_cfg1;
			cfg2 <= next_cfg2;
			cfg3 <= next_cfg3;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decoded controls, registered so every output leaves a flip-flop.
	always_comb begin
		next_outs.readback_multi   = cfg1[CFG1_READBACK_BIT];
		// The oscillator only reaches the pin when the clock-source pin selects it.
		next_outs.osc_clk_out_en   = cfg1[CFG1_OSC_OUT_BIT] && clock_source_pin;
		next_outs.output_rate_code = cfg1[CFG1_RATE_LSB +: 3];
		next_outs.result_24bit     = (cfg1[CFG1_RATE_LSB +: 3] > RATE_LAST_16BIT) &&
			(cfg1[CFG1_RATE_LSB +: 3] != RATE_FORBIDDEN);
		next_outs.test_internal    = cfg2[CFG2_INT_TEST_BIT];
		next_outs.test_amp_x2      = cfg2[CFG2_AMP_BIT];
		next_outs.test_frequency_select = cfg2[CFG2_FREQ_LSB +: 2];
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			// The oscillator stays off until the pin is seen; the reset rate is a wide code.
			outs <= '{
				readback_multi:        CFG1_RESET[CFG1_READBACK_BIT],
				osc_clk_out_en:        1'b0,
				output_rate_code:      CFG1_RESET[CFG1_RATE_LSB +: 3],
				result_24bit:          1'b1,
				test_internal:         CFG2_RESET[CFG2_INT_TEST_BIT],
				test_amp_x2:           CFG2_RESET[CFG2_AMP_BIT],
				test_frequency_select: CFG2_RESET[CFG2_FREQ_LSB +: 2]
			};
		end else begin
			outs <= next_outs;
		end
	end

	// Direct output wiring from the registered state.
	assign dout                  = s.dout;
	assign dout_oe_n             = s.dout_oe_n;
	assign readback_multi        = outs.readback_multi;
	assign osc_clk_out_en        = outs.osc_clk_out_en;
	assign output_rate_code      = outs.output_rate_code;
	assign result_24bit          = outs.result_24bit;
	assign test_internal         = outs.test_internal;
	assign test_amp_x2           = outs.test_amp_x2;
	assign test_frequency_select = outs.test_frequency_select;

	////////////////////////////////////////////////////////////////////////////////
	// Rate and test-signal divider driven from the decoded controls.
	afe_rate_gen #(
		.SLOW_LOG2(TEST_SLOW_DIV_LOG2),
		.FAST_LOG2(TEST_FAST_DIV_LOG2)
	) u_rate_gen (
		.core_clk   (core_clk),
		.rst_n      (rst_n),
		.rate_code  (outs.output_rate_code),
		.freq_sel   (outs.test_frequency_select),
		.sample_tick(sample_tick),
		.test_wave  (test_signal)
	);

endmodule

/* afe_cfg_pkg.sv */
// Constants, field layouts and carrier types for the converter configuration register bank.
package afe_cfg_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register addresses.
	localparam logic [4:0] ADDR_ID   = 5'h00;
	localparam logic [4:0] ADDR_CFG1 = 5'h01;
	localparam logic [4:0] ADDR_CFG2 = 5'h02;
	localparam logic [4:0] ADDR_CFG3 = 5'h03;

	// Identification pattern built field by field; the family bit is held apart.
	localparam logic [7:0] ID_FIXED_PATTERN = {2'h3, 1'h0, 1'h1, 2'h0, 1'h1, 1'h0};
	localparam int         ID_FAMILY_BIT    = 5;
	localparam logic       FAMILY_CODE      = 1'b0;

	// Reset values.
	localparam logic [7:0] CFG1_RESET = 8'h94;
	localparam logic [7:0] CFG2_RESET = 8'h00;
	localparam logic [7:0] CFG3_RESET = 8'hE0;

	// Bits that read fixed regardless of what was written.
	localparam logic [7:0] CFG2_READ_ONES  = 8'hE0;
	localparam logic [7:0] CFG2_READ_ZEROS = 8'h08;
	localparam logic [7:0] CFG3_READ_ZEROS = 8'h01;

	// Field positions.
	localparam int CFG1_READBACK_BIT = 6;
	localparam int CFG1_OSC_OUT_BIT  = 5;
	localparam int CFG1_RATE_LSB     = 0;
	localparam int CFG2_INT_TEST_BIT = 4;
	localparam int CFG2_AMP_BIT      = 2;
	localparam int CFG2_FREQ_LSB     = 0;

	// Serial command opcodes, upper three bits of the first byte.
	localparam logic [2:0] OP_READ  = 3'h1;
	localparam logic [2:0] OP_WRITE = 3'h2;

	// Output rate codes.
	localparam logic [2:0] RATE_LAST_16BIT = 3'h1;
	localparam logic [2:0] RATE_FORBIDDEN  = 3'h7;

	// Fastest rate is the master clock divided by this; each code step doubles it.
	localparam int MASTER_CLK_KHZ    = 2048;
	localparam int FASTEST_RATE_KSPS = 64;
	localparam int RATE_BASE_DIV     = MASTER_CLK_KHZ / FASTEST_RATE_KSPS;
	localparam int RATE_BASE_LOG2    = $clog2(RATE_BASE_DIV);

	// Test signal frequency selections and their divider exponents.
	localparam logic [1:0] FREQ_SLOW   = 2'h0;
	localparam logic [1:0] FREQ_FAST   = 2'h1;
	localparam logic [1:0] FREQ_UNUSED = 2'h2;
	localparam logic [1:0] FREQ_DC     = 2'h3;
	localparam int         TEST_SLOW_LOG2 = 21;
	localparam int         TEST_FAST_LOG2 = 20;

	////////////////////////////////////////////////////////////////////////////////
	// Serial phases, one-hot.
	typedef enum logic [3:0] {
		PH_CMD   = 4'h1,
		PH_COUNT = 4'h2,
		PH_DATA  = 4'h4,
		PH_SKIP  = 4'h8
	} spi_phase_t;

	typedef struct packed {
		spi_phase_t  phase;
		logic        sclk_q;
		logic [2:0]  rx_cnt;
		logic [7:0]  rx_shift;
		logic [2:0]  tx_cnt;
		logic [7:0]  tx_shift;
		logic        is_write;
		logic [4:0]  addr;
		logic [4:0]  remain;
		logic        dout;
		logic        dout_oe_n;
	} spi_state_t;

	typedef struct packed {
		logic        readback_multi;
		logic        osc_clk_out_en;
		logic [2:0]  output_rate_code;
		logic        result_24bit;
		logic        test_internal;
		logic        test_amp_x2;
		logic [1:0]  test_frequency_select;
	} cfg_out_t;

endpackage

/* afe_rate_gen.sv */
// Master clock divider producing the sample tick and the test waveform.
`timescale 1ns/1ps
module afe_rate_gen
	import afe_cfg_pkg::*;
#(
	parameter int SLOW_LOG2 = TEST_SLOW_LOG2,
	parameter int FAST_LOG2 = TEST_FAST_LOG2
) (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] rate_code,
	input  wire logic [1:0] freq_sel,
	output logic            sample_tick,
	output logic            test_wave
);

	// The counter must span the slowest sample rate even when the test taps are shortened,
	// otherwise the rate mask is cut and slow codes tick far too often.
	localparam int CNT_W = (SLOW_LOG2 > RATE_BASE_LOG2 + int'(RATE_FORBIDDEN)) ?
		SLOW_LOG2 : RATE_BASE_LOG2 + int'(RATE_FORBIDDEN);

	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic             next_tick;
	logic             next_wave;
	logic [CNT_W-1:0] rate_mask;

	////////////////////////////////////////////////////////////////////////////////
	// The counter runs freely so that every rate stays phase-locked to the clock.
	always_comb begin
		next_cnt  = cnt + 1'b1;
		rate_mask = CNT_W'((1 << (RATE_BASE_LOG2 + int'(rate_code))) - 1);
		next_tick = ((cnt & rate_mask) == '0) && (rate_code != RATE_FORBIDDEN);
		case (freq_sel)
			FREQ_SLOW: next_wave = cnt[SLOW_LOG2-1];
			FREQ_FAST: next_wave = cnt[FAST_LOG2-1];
			FREQ_DC:   next_wave = 1'b1;
			default:   next_wave = 1'b0; // Unused code holds the wave low.
		endcase
	end

	// Registered so both outputs come from flip-flops.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt         <= '0;
			sample_tick <= 1'b0;
			test_wave   <= 1'b0;
		end else begin
			cnt         <= next_cnt;
			sample_tick <= next_tick;
			test_wave   <= next_wave;
		end
	end

endmodule

/* afe_cfg_regs_sva.sv */
// Port-level checker for the configuration register bank.
`timescale 1ns/1ps
module afe_cfg_regs_sva
	import afe_cfg_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       cs_n,
	input wire logic       sclk,
	input wire logic       din,
	input wire logic       clock_source_pin,
	input wire logic       dout,
	input wire logic       dout_oe_n,
	input wire logic       readback_multi,
	input wire logic       osc_clk_out_en,
	input wire logic [2:0] output_rate_code,
	input wire logic       result_24bit,
	input wire logic       test_internal,
	input wire logic       test_amp_x2,
	input wire logic [1:0] test_frequency_select,
	input wire logic       sample_tick,
	input wire logic       test_signal
);
	// One domain, so clock and reset are given once.
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////////////
	// Width flag must agree with the rate code at all times.
	rate_width_a: assert property (result_24bit ==
		(output_rate_code inside {[3'h2:3'h6]}))
		else $error("result width disagrees with rate code");
	// No command can land before the first edge, so defaults must show there.
	reset_vals_a: assert property ($rose(rst_n) |->
		output_rate_code == 3'h4 && result_24bit
		&& !readback_multi && !osc_clk_out_en && !test_internal && !test_amp_x2)
		else $error("outputs not at defaults after reset");
	// A deselected device leaves its data line undriven and low.
	oe_idle_a: assert property (cs_n && $past(cs_n) |-> dout_oe_n && !dout)
		else $error("data out driven while deselected");
	oe_drive_a: assert property (!cs_n && !$past(cs_n) && $past(rst_n) |-> !dout_oe_n)
		else $error("data out not driven while selected");
	// Oscillator output only ever follows a high clock-source pin.
	osc_pin_a: assert property (osc_clk_out_en |-> $past(clock_source_pin))
		else $error("oscillator output without source pin");
	// Ticks are single pulses spaced far apart at every rate code.
	tick_pulse_a: assert property (sample_tick |=> !sample_tick [*8])
		else $error("sample ticks too close");
	test_dc_a: assert property ((test_frequency_select == FREQ_DC) [*3] |->
		test_signal)
		else $error("dc test level not high");
	test_off_a: assert property ((test_frequency_select == FREQ_UNUSED) [*3] |->
		!test_signal)
		else $error("unused test setting not low");

	// Main scenarios reached.
	cover property (sample_tick);
	cover property (osc_clk_out_en);
	cover property (!dout_oe_n && dout);
endmodule

bind afe_cfg_regs afe_cfg_regs_sva chk_i (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n),
	.sclk(sclk), .din(din), .clock_source_pin(clock_source_pin), .dout(dout),
	.dout_oe_n(dout_oe_n), .readback_multi(readback_multi), .osc_clk_out_en(osc_clk_out_en),
	.output_rate_code(output_rate_code), .result_24bit(result_24bit),
	.test_internal(test_internal), .test_amp_x2(test_amp_x2),
	.test_frequency_select(test_frequency_select), .sample_tick(sample_tick),
	.test_signal(test_signal));

/* afe_host_model.sv */
// Serial host model that frames commands and shifts bytes MSB first.
`timescale 1ns/1ps
module afe_host_model (
	input  wire logic core_clk,
	input  wire logic dout,
	output logic      cs_n,
	output logic      sclk,
	output logic      din
);
	// Idle bus: deselected, clock parked low.
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din  = 1'b0;
	end
	task automatic open_frame();
		cs_n = 1'b0;
		@(negedge core_clk);
	endtask
	// Two master clocks per phase, the shortest the block can sample reliably.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			din  = tx[i];
			sclk = 1'b1;
			repeat (2) @(negedge core_clk);
			rx[i] = dout;
			sclk  = 1'b0;
			repeat (2) @(negedge core_clk);
		end
	endtask
	// Released data line shows the inverse of its last bit so stale values cannot pass.
	task automatic close_frame();
		cs_n = 1'b1;
		din  = ~din;
		repeat (2) @(negedge core_clk);
	endtask
endmodule

/* adc_afe_config_registers_bench.sv */
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
module adc_afe_config_registers_bench;
	import afe_cfg_pkg::*;
	localparam logic [7:0] ID_EXP = {2'h3, 1'h0, 1'h1, 2'h0, 1'h1, 1'h0};
	logic       core_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       clock_source_pin = 1'b0;
	logic       cs_n, sclk, din, dout, oe_n, rb, osc, r24, ti, amp, tick, ts;
	logic [2:0] rate;
	logic [1:0] fsel;
	int         err_total = 0;
	int         n_tests = 0;

	// Free-running master clock.
	always #10 core_clk = ~core_clk;

	// Short test dividers keep the waveform checks quick.
	afe_cfg_regs #(.TEST_SLOW_DIV_LOG2(6), .TEST_FAST_DIV_LOG2(5)) uut (
		.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
		.clock_source_pin(clock_source_pin), .dout(dout), .dout_oe_n(oe_n),
		.readback_multi(rb), .osc_clk_out_en(osc), .output_rate_code(rate),
		.result_24bit(r24), .test_internal(ti), .test_amp_x2(amp),
		.test_frequency_select(fsel), .sample_tick(tick), .test_signal(ts));
	afe_host_model host (.core_clk(core_clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done();
		$display("Comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Single-register write and read, count byte zero.
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] rx;
		host.open_frame();
		host.xfer({OP_WRITE, a}, rx);
		host.xfer(8'h00, rx);
		host.xfer(d, rx);
		host.close_frame();
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] rx;
		host.open_frame();
		host.xfer({OP_READ, a}, rx);
		host.xfer(8'h00, rx);
		host.xfer(8'h00, rx);
		host.close_frame();
		chk("read", exp, rx);
	endtask
	// Spacing of two sample ticks in master clocks; a dead divider ends the run.
	task automatic tick_gap(input int exp);
		int n;
		int gap;
		n = 0;
		gap = 0;
		while (tick !== 1'b1 && n < 5000) begin
			@(negedge core_clk);
			n++;
		end
		do begin
			@(negedge core_clk);
			gap++;
		end while (tick !== 1'b1 && gap < 5000);
		n_tests++;
		if (n >= 5000 || gap >= 5000) begin
			err_total++;
			$display("ERROR tick gap expected %0d seen none", exp);
			test_done();
		end else if (gap != exp) begin
			err_total++;
			$display("ERROR tick gap expected %0d seen %0d", exp, gap);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset, then one burst read across the first four addresses.
	task automatic reset_all();
		logic [7:0] exp [4];
		logic [7:0] rx;
		exp = '{ID_EXP, 8'h94, 8'hE0, 8'hE0};
		rst_n = 1'b0;
		repeat (20) @(negedge core_clk);
		rst_n = 1'b1;
		chk("rate", 8'h04, {5'h00, rate});
		chk("flags", 8'h01, {5'h00, rb, osc, r24});
		host.open_frame();
		host.xfer({OP_READ, ADDR_ID}, rx);
		host.xfer(8'h03, rx);
		for (int i = 0; i < 4; i++) begin
			host.xfer(8'h00, rx);
			chk("burst", exp[i], rx);
		end
		host.close_frame();
	endtask
	task automatic rates();
		for (int c = 0; c < 7; c++) begin
			wr(ADDR_CFG1, 8'hD0 | 8'(c));
			repeat (3) @(negedge core_clk);
			chk("rate", 8'(c), {5'h00, rate});
			chk("wide", {7'h00, c > 1}, {7'h00, r24});
			tick_gap(RATE_BASE_DIV << c);
		end
		chk("mode", 8'h01, {7'h00, rb});
		rd(ADDR_CFG1, 8'hD6);
	endtask
	task automatic osc_pin();
		wr(ADDR_CFG1, 8'hB4);
		repeat (3) @(negedge core_clk);
		chk("mode", 8'h00, {7'h00, rb});
		chk("osc off", 8'h00, {7'h00, osc});
		clock_source_pin = 1'b1;
		repeat (3) @(negedge core_clk);
		chk("osc on", 8'h01, {7'h00, osc});
		clock_source_pin = 1'b0;
	endtask
	// Every frequency code, with dc and unused levels checked after settling.
	task automatic tests();
		for (int f = 0; f < 4; f++) begin
			wr(ADDR_CFG2, 8'hF4 | 8'(f));
			repeat (4) @(negedge core_clk);
			chk("test", {4'h0, 2'h3, 2'(f)}, {4'h0, ti, amp, fsel});
			if (f > 1) chk("level", {7'h00, f == 3}, {7'h00, ts});
		end
		rd(ADDR_CFG2, 8'hF7);
		wr(ADDR_CFG2, 8'hE0);
		repeat (3) @(negedge core_clk);
		chk("test off", 8'h00, {6'h00, ti, amp});
	endtask
	task automatic id_unmapped();
		wr(ADDR_ID, 8'h00);
		rd(ADDR_ID, ID_EXP);
		rd(5'h1F, 8'h00);
	endtask

	// Main sequence, ending with a mid-run reset.
	initial begin
		reset_all();
		rates();
		osc_pin();
		tests();
		id_unmapped();
		reset_all();
		test_done();
	end
	// Hang guard.
	initial begin
		repeat (100000) @(posedge core_clk);
		err_total++;
		test_done();
	end
endmodule
